// ### logic/port_policy_params.svh
// Function
// - disabled port neither receives nor transmits frames
// - auto mode takes negotiated speed and duplex
// - forced mode uses configured speed and duplex
// - speed/duplex writable only forced; auto shows result
// - flow control on: pause sender when overloaded
// - flow control off: drop frames when overloaded
// - ingress rate limit 0..8000 in 128K steps
// - egress rate limit 0..8000, enforced on output
// - zero disables limiting; 1..8000 enforced rates
// - ingress limit enforced by pause toward partner
// - secure port learns no new source addresses
// - secure port forwards only known source addresses
// - storm filter enable per port, global mode
// - jumbo option on: forward jumbo frames
// - jumbo frames up to nine kilobytes
`ifndef PORT_POLICY_PARAMS_SVH
`define PORT_POLICY_PARAMS_SVH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_ING_RATE    8'h04
`define REG_EGR_RATE    8'h08
`define REG_STATUS      8'h0C
`define REG_DROPS       8'h10

// control register fields
`define CTRL_EN         0
`define CTRL_FORCE      1
`define CTRL_SPD_LO     2
`define CTRL_SPD_HI     3
`define CTRL_FDX        4
`define CTRL_FC         5
`define CTRL_SEC        6
`define CTRL_STORM      7
`define CTRL_JUMBO      8
`define CTRL_RESET      9'h1B5

// status register fields
`define STAT_LINK       0
`define STAT_SPD_LO     1
`define STAT_SPD_HI     2
`define STAT_FDX        3
`define STAT_PAUSE      4
`define STAT_ING_OVER   5
`define STAT_EGR_OVER   6
`define STAT_LVL_LO     8

// rate limiting
`define RATE_W          13
`define RATE_MAX        13'h1F40
`define CLK_HZ          100000000
`define RATE_UNIT_BPS   128000
`define BYTE_COST       ((`CLK_HZ * 8) / `RATE_UNIT_BPS)
`define BURST_BYTES     2048
`define BUCKET_CAP      (`BYTE_COST * `BURST_BYTES)

// frame lengths in bytes
`define STD_MAX_LEN     14'h05EE
`define JUMBO_MAX_LEN   14'h2400

// ingress buffer
`define FIFO_DEPTH      16
`define PAUSE_HI_LVL    5'h0C
`define PAUSE_LO_LVL    5'h04

`endif

// ### logic/port_policy_pkg.sv
package port_policy_pkg;

  // one byte of a frame
  typedef struct packed {
    logic       err;
    logic       last;
    logic [7:0] data;
  } beat_t;

  // lookups for the frame now starting, valid with its first byte
  typedef struct packed {
    logic sa_known;
    logic storm_hit;
  } frame_info_t;

  // link state from the transceiver pins
  typedef struct packed {
    logic       link_up;
    logic [1:0] speed;
    logic       full;
  } phy_status_t;

  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10
  } link_speed_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PASS  = 2'b01,
    ST_DROP  = 2'b10,
    ST_ABORT = 2'b11
  } rx_state_t;

endpackage

// ### logic/frame_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // fill side
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            in_ready,
  // drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  // occupancy including the output stage
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             wr;
  logic             rd;

  // output stage is a flop so the drain never sees memory read timing
  assign in_ready = count_q < CW'(DEPTH);
  assign wr       = in_valid && in_ready;
  assign rd       = (count_q != '0) && (!out_valid || out_ready);
  assign level    = count_q + CW'(out_valid);

  always_ff @(posedge pclk) begin
    if (wr) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + CW'(wr) - CW'(rd);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (rd) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### logic/switch_port_policy_control.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "port_policy_params.svh"
module switch_port_policy_control
  import port_policy_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // transceiver negotiation
  input  wire phy_status_t  phy_status,
  output logic              an_enable,
  output logic [1:0]        force_speed,
  output logic              force_full,
  // receive stream from the link
  input  wire logic         rx_valid,
  input  wire beat_t        rx_beat,
  input  wire frame_info_t  rx_info,
  output logic              pause_req,
  // address learning
  output logic              learn_en,
  output logic              learn_req,
  // forward stream toward the fabric
  output logic              fwd_valid,
  output beat_t             fwd_beat,
  input  wire logic         fwd_ready,
  // egress stream from the fabric
  input  wire logic         eg_valid,
  input  wire beat_t        eg_beat,
  output logic              eg_ready,
  // transmit stream toward the link
  output logic              tx_valid,
  output beat_t             tx_beat,
  input  wire logic         tx_ready
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  // token bucket, credit per cycle equals the rate setting
  function automatic logic signed [31:0] bucket_next(
    input logic signed [31:0] b,
    input logic [`RATE_W-1:0] rate,
    input logic               spend
  );
    logic signed [31:0] n;
    n = b + $signed({19'h0, rate}) - (spend ? 32'(`BYTE_COST) : 32'sh0);
    if (rate == '0) begin
      n = 32'sh0;
    end else if (n > 32'(`BUCKET_CAP)) begin
      n = 32'(`BUCKET_CAP);
    end
    return n;
  endfunction

  logic [8:0]              ctrl_q;
  logic [`RATE_W-1:0]      ing_rate_q;
  logic [`RATE_W-1:0]      egr_rate_q;
  logic [31:0]             drops_q;
  phy_status_t             sync1_q;
  phy_status_t             sync2_q;
  phy_status_t             sync3_q;
  phy_status_t             phy_q;
  logic                    wr_acc;
  logic                    rd_sel;
  logic [31:0]             rd_data;
  logic                    rd_hit;
  logic [1:0]              act_speed;
  logic                    act_full;
  logic                    en;
  logic signed [31:0]      ing_bkt_q;
  logic signed [31:0]      egr_bkt_q;
  logic                    ing_over;
  logic                    egr_over;
  rx_state_t               rx_state_q;
  rx_state_t               rx_state_d;
  logic [13:0]             len_q;
  logic [13:0]             len_d;
  logic                    seen_last_q;
  logic                    seen_last_d;
  logic [13:0]             max_len;
  logic                    push;
  beat_t                   push_beat;
  logic                    drop_evt;
  logic                    learn_d;
  logic                    fifo_in_ready;
  logic [LW-1:0]           level;
  logic                    eg_take;
  logic                    eg_send;
  beat_t                   eg_out;
  logic                    eg_drop_q;
  logic                    eg_drop_d;
  logic [13:0]             eg_len_q;
  logic [13:0]             eg_len_d;
  logic                    tx_valid_d;

  assign en       = ctrl_q[`CTRL_EN];
  assign max_len  = ctrl_q[`CTRL_JUMBO] ? `JUMBO_MAX_LEN : `STD_MAX_LEN;
  assign ing_over = (ing_rate_q != '0) && ing_bkt_q[31];
  assign egr_over = (egr_rate_q != '0) && egr_bkt_q[31];

  // pins are asynchronous: take a change once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      phy_q   <= '0;
    end else begin
      sync1_q <= phy_status;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        phy_q <= sync3_q;
      end
    end
  end

  // forced mode uses the stored values, auto takes the negotiated ones
  always_comb begin
    if (ctrl_q[`CTRL_FORCE]) begin
      act_speed = ctrl_q[`CTRL_SPD_HI:`CTRL_SPD_LO];
      act_full  = ctrl_q[`CTRL_FDX];
    end else begin
      act_speed = phy_q.speed;
      act_full  = phy_q.full;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_enable   <= 1'b1;
      force_speed <= SPD_100;
      force_full  <= 1'b1;
    end else begin
      an_enable   <= !ctrl_q[`CTRL_FORCE];
      force_speed <= ctrl_q[`CTRL_SPD_HI:`CTRL_SPD_LO];
      force_full  <= ctrl_q[`CTRL_FDX];
    end
  end

  // apb: answer in the second access cycle, write lands at that edge
  assign rd_sel = psel && penable && !pready;
  assign wr_acc = psel && penable && pready && pwrite;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      `REG_CTRL: begin
        rd_data[8:0]                      = ctrl_q;
        rd_data[`CTRL_SPD_HI:`CTRL_SPD_LO] = act_speed;
        rd_data[`CTRL_FDX]                 = act_full;
      end
      `REG_ING_RATE: begin
        rd_data[`RATE_W-1:0] = ing_rate_q;
      end
      `REG_EGR_RATE: begin
        rd_data[`RATE_W-1:0] = egr_rate_q;
      end
      `REG_STATUS: begin
        rd_data[`STAT_LINK]                 = phy_q.link_up;
        rd_data[`STAT_SPD_HI:`STAT_SPD_LO]  = act_speed;
        rd_data[`STAT_FDX]                  = act_full;
        rd_data[`STAT_PAUSE]                = pause_req;
        rd_data[`STAT_ING_OVER]             = ing_over;
        rd_data[`STAT_EGR_OVER]             = egr_over;
        rd_data[`STAT_LVL_LO +: LW]         = level;
      end
      `REG_DROPS: begin
        rd_data = drops_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_sel;
      if (rd_sel) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= !rd_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `CTRL_RESET;
      ing_rate_q <= '0;
      egr_rate_q <= '0;
    end else if (wr_acc) begin
      case (paddr)
        `REG_CTRL: begin
          ctrl_q[`CTRL_EN]    <= pwdata[`CTRL_EN];
          ctrl_q[`CTRL_FORCE] <= pwdata[`CTRL_FORCE];
          ctrl_q[`CTRL_FC]    <= pwdata[`CTRL_FC];
          ctrl_q[`CTRL_SEC]   <= pwdata[`CTRL_SEC];
          ctrl_q[`CTRL_STORM] <= pwdata[`CTRL_STORM];
          ctrl_q[`CTRL_JUMBO] <= pwdata[`CTRL_JUMBO];
          if (pwdata[`CTRL_FORCE]) begin
            ctrl_q[`CTRL_SPD_HI:`CTRL_SPD_LO] <= pwdata[`CTRL_SPD_HI:`CTRL_SPD_LO];
            ctrl_q[`CTRL_FDX]                 <= pwdata[`CTRL_FDX];
          end
        end
        `REG_ING_RATE: begin
          if (pwdata[31:0] <= 32'(`RATE_MAX)) begin
            ing_rate_q <= pwdata[`RATE_W-1:0];
          end
        end
        `REG_EGR_RATE: begin
          if (pwdata[31:0] <= 32'(`RATE_MAX)) begin
            egr_rate_q <= pwdata[`RATE_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // receive side: decide a frame's fate on its first byte
  always_comb begin
    rx_state_d  = rx_state_q;
    len_d       = len_q;
    seen_last_d = seen_last_q;
    push        = 1'b0;
    push_beat   = rx_beat;
    drop_evt    = 1'b0;
    learn_d     = 1'b0;
    case (rx_state_q)
      ST_IDLE: begin
        if (rx_valid) begin
          if (!en
              || (ctrl_q[`CTRL_SEC] && !rx_info.sa_known)
              || (ctrl_q[`CTRL_STORM] && rx_info.storm_hit)
              || !fifo_in_ready) begin
            drop_evt   = 1'b1;
            rx_state_d = rx_beat.last ? ST_IDLE : ST_DROP;
          end else begin
            push       = 1'b1;
            len_d      = 14'h0001;
            rx_state_d = rx_beat.last ? ST_IDLE : ST_PASS;
            learn_d    = !ctrl_q[`CTRL_SEC] && !rx_info.sa_known;
          end
        end
      end
      ST_PASS: begin
        if (rx_valid) begin
          // a buffer overrun or oversize frame is cut and marked bad
          if (!en || !fifo_in_ready || len_q >= max_len) begin
            drop_evt    = 1'b1;
            seen_last_d = rx_beat.last;
            rx_state_d  = ST_ABORT;
          end else begin
            push       = 1'b1;
            len_d      = len_q + 14'h0001;
            rx_state_d = rx_beat.last ? ST_IDLE : ST_PASS;
          end
        end
      end
      ST_ABORT: begin
        if (rx_valid && rx_beat.last) begin
          seen_last_d = 1'b1;
        end
        if (fifo_in_ready) begin
          push       = 1'b1;
          push_beat  = '{err: 1'b1, last: 1'b1, data: 8'h00};
          rx_state_d = (seen_last_q || (rx_valid && rx_beat.last)) ? ST_IDLE : ST_DROP;
        end
      end
      ST_DROP: begin
        if (rx_valid && rx_beat.last) begin
          rx_state_d = ST_IDLE;
        end
      end
      default: begin
        rx_state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q  <= ST_IDLE;
      len_q       <= '0;
      seen_last_q <= 1'b0;
      drops_q     <= '0;
      learn_req   <= 1'b0;
      learn_en    <= 1'b0;
    end else begin
      rx_state_q  <= rx_state_d;
      len_q       <= len_d;
      seen_last_q <= seen_last_d;
      learn_req   <= learn_d;
      learn_en    <= en && !ctrl_q[`CTRL_SEC];
      if (drop_evt && drops_q != 32'hFFFF_FFFF) begin
        drops_q <= drops_q + 32'h0000_0001;
      end
    end
  end

  // ingress rate is held by pausing the partner, not by dropping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ing_bkt_q <= '0;
      egr_bkt_q <= '0;
      pause_req <= 1'b0;
    end else begin
      ing_bkt_q <= bucket_next(ing_bkt_q, ing_rate_q, push && !push_beat.err);
      egr_bkt_q <= bucket_next(egr_bkt_q, egr_rate_q, eg_send);
      // hysteresis keeps the link from flapping between pause and resume
      pause_req <= en && ((ctrl_q[`CTRL_FC]
                           && (level >= LW'(`PAUSE_HI_LVL)
                               || (pause_req && level > LW'(`PAUSE_LO_LVL))))
                          || ing_over);
    end
  end

  frame_fifo #(
    .WIDTH ($bits(beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_data   (push_beat),
    .in_ready  (fifo_in_ready),
    .out_valid (fwd_valid),
    .out_ready (fwd_ready),
    .out_data  (fwd_beat),
    .level     (level)
  );

  // egress: sent beats one per two cycles at most, paced by the bucket; discarded beats may be taken every cycle
  always_comb begin
    eg_take   = eg_valid && eg_ready;
    eg_send   = 1'b0;
    eg_out    = eg_beat;
    eg_drop_d = eg_drop_q;
    eg_len_d  = eg_len_q;
    if (eg_take) begin
      if (eg_drop_q) begin
        eg_drop_d = !eg_beat.last;
      end else if (!en) begin
        eg_drop_d = !eg_beat.last;
      end else if (eg_len_q >= max_len) begin
        eg_send    = 1'b1;
        eg_out.err  = 1'b1;
        eg_out.last = 1'b1;
        eg_drop_d  = !eg_beat.last;
        eg_len_d   = '0;
      end else begin
        eg_send  = 1'b1;
        eg_len_d = eg_beat.last ? 14'h0000 : eg_len_q + 14'h0001;
      end
    end
    tx_valid_d = eg_send || (tx_valid && !tx_ready);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eg_drop_q <= 1'b0;
      eg_len_q  <= '0;
      eg_ready  <= 1'b0;
      tx_valid  <= 1'b0;
      tx_beat   <= '0;
    end else begin
      eg_drop_q <= eg_drop_d;
      eg_len_q  <= eg_len_d;
      eg_ready  <= eg_drop_d || !en || (!egr_over && !tx_valid_d);
      tx_valid  <= tx_valid_d;
      if (eg_send) begin
        tx_beat <= eg_out;
      end
    end
  end

endmodule
`default_nettype wire

// ### testbench/switch_port_policy_control_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_policy_params.svh"
module switch_port_policy_control_chk
  import port_policy_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // negotiation and learning
  input wire logic        an_enable,
  input wire logic [1:0]  force_speed,
  input wire logic        learn_en,
  input wire logic        learn_req,
  // streams
  input wire logic        fwd_valid,
  input wire beat_t       fwd_beat,
  input wire logic        fwd_ready,
  input wire logic        eg_valid,
  input wire logic        eg_ready,
  input wire logic        tx_valid,
  input wire beat_t       tx_beat,
  input wire logic        tx_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctrl_wr;
  assign ctrl_wr = pready && psel && pwrite && paddr == `REG_CTRL;

  a_apb_ready_slot: assert property (psel && penable && !pready |=> pready && penable)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  a_unmapped_err: assert property (pready && paddr > `REG_DROPS |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_force_mode: assert property (ctrl_wr |-> ##2 an_enable == !$past(pwdata[1], 2))
    else $error("negotiation mode not taken");
  a_speed_store: assert property (ctrl_wr && pwdata[1] |-> ##2 force_speed == $past(pwdata[3:2], 2))
    else $error("forced speed not stored");
  a_speed_keep: assert property (ctrl_wr && !pwdata[1] |-> ##2 force_speed == $past(force_speed, 2))
    else $error("speed written in auto");
  a_learn_gate: assert property (learn_req |-> learn_en)
    else $error("learning on locked port");
  a_fwd_hold: assert property (fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_beat))
    else $error("forward beat dropped");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
    else $error("transmit beat dropped");
  // discarded or truncated beats may be taken back to back, only sent ones pace
  a_eg_spacing: assert property (eg_valid && eg_ready ##1 $rose(tx_valid) && !tx_beat.err
                                 |-> !eg_ready)
    else $error("egress taken back to back");
endmodule

bind switch_port_policy_control switch_port_policy_control_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .an_enable(an_enable), .force_speed(force_speed), .learn_en(learn_en),
  .learn_req(learn_req), .fwd_valid(fwd_valid), .fwd_beat(fwd_beat), .fwd_ready(fwd_ready),
  .eg_valid(eg_valid), .eg_ready(eg_ready), .tx_valid(tx_valid), .tx_beat(tx_beat),
  .tx_ready(tx_ready)
);
`default_nettype wire

// ### testbench/link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
module link_partner_model
  import port_policy_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // link toward the port
  output var phy_status_t phy_status,
  output logic            rx_valid,
  output beat_t           rx_beat,
  output frame_info_t     rx_info,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic stall = 1'b0;

  initial begin
    phy_status = '{1'b1, 2'b10, 1'b1};
    rx_valid = 1'b0;
    rx_beat = '0;
    rx_info = '0;
    tx_ready = 1'b1;
  end

  // a busy station holds off at random while a frame is coming
  always @(posedge pclk)
    tx_ready <= !(stall && tx_valid && $urandom % 2);

  task automatic send(input int len, input logic [7:0] base, input frame_info_t info);
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_beat <= '{1'b0, i == len - 1, base + 8'(i)};
      // lookups mean something only with the first byte
      rx_info <= i == 0 ? info : ~info;
      @(posedge pclk);
    end
    rx_valid <= 1'b0;
    rx_beat <= ~rx_beat;
    rx_info <= ~info;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_switch_port_policy_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_policy_params.svh"
module tb_switch_port_policy_control
  import port_policy_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, an_enable, force_full;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  force_speed;
  logic        rx_valid, pause_req, learn_en, learn_req, fwd_valid, eg_valid, eg_ready;
  logic        tx_valid, tx_ready, loose;
  logic        fwd_ready = 1'b0;
  phy_status_t phy_status;
  frame_info_t rx_info;
  beat_t       rx_beat, fwd_beat, eg_beat, tx_beat, last_fwd;
  logic [32:0] exp_rd[$];
  beat_t       exp_fwd[$], exp_tx[$];
  int          n_fail = 0, n_checks = 0, n_learn = 0, n_tx = 0, fr_mode = 1, t0, r;

  switch_port_policy_control #(.FIFO_DEPTH(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .phy_status(phy_status), .an_enable(an_enable), .force_speed(force_speed),
    .force_full(force_full), .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_info(rx_info),
    .pause_req(pause_req), .learn_en(learn_en), .learn_req(learn_req),
    .fwd_valid(fwd_valid), .fwd_beat(fwd_beat), .fwd_ready(fwd_ready),
    .eg_valid(eg_valid), .eg_beat(eg_beat), .eg_ready(eg_ready),
    .tx_valid(tx_valid), .tx_beat(tx_beat), .tx_ready(tx_ready)
  );

  link_partner_model lp (
    .pclk(pclk), .phy_status(phy_status), .rx_valid(rx_valid), .rx_beat(rx_beat),
    .rx_info(rx_info), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    if (!w)
      exp_rd.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50)
      n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_q();
    int n;
    n = 0;
    while ((exp_fwd.size() || exp_tx.size()) && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20000)
      n_fail++;
    repeat (8) @(posedge pclk);
  endtask

  // keep = 0: whole frame refused; keep < len: cut short by an error beat
  task automatic rx_frame(input int len, input int keep, input frame_info_t info);
    logic [7:0] base;
    base = 8'($urandom);
    for (int i = 0; i < keep; i++)
      exp_fwd.push_back('{1'b0, i == len - 1, base + 8'(i)});
    if (keep > 0 && keep < len)
      exp_fwd.push_back('{1'b1, 1'b1, 8'h00});
    lp.send(len, base, info);
    if (fr_mode)
      wait_q();
  endtask

  task automatic eg_send(input int len, input logic en);
    int n;
    beat_t b;
    for (int i = 0; i < len; i++) begin
      b = '{1'b0, i == len - 1, 8'($urandom)};
      if (en)
        exp_tx.push_back(b);
      eg_valid <= 1'b1;
      eg_beat <= b;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (eg_ready !== 1'b1 && n < 20000);
    end
    eg_valid <= 1'b0;
    eg_beat <= ~b;
  endtask

  always @(posedge pclk)
    fwd_ready <= fr_mode == 2 ? 1'($urandom) : fr_mode[0];

  always @(posedge pclk) begin
    if (pready === 1'b1 && psel && !pwrite)
      chk({pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 'x);
    if (fwd_valid === 1'b1 && fwd_ready && loose)
      last_fwd = fwd_beat;
    else if (fwd_valid === 1'b1 && fwd_ready)
      chk(fwd_beat, exp_fwd.size() ? exp_fwd.pop_front() : 'x);
    if (tx_valid === 1'b1 && tx_ready) begin
      n_tx++;
      chk(tx_beat, exp_tx.size() ? exp_tx.pop_front() : 'x);
    end
    if (learn_req === 1'b1)
      n_learn++;
  end

  initial begin
    repeat (80000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, eg_valid, eg_beat, loose} = '0;
    void'($urandom(32'hA5A926DA));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(0, `REG_CTRL, 0, 33'h1B9);
    apb(0, `REG_STATUS, 0, 33'h0D);
    apb(0, 8'h20, 0, 33'h100000000);
    // limiter tests first: buckets are still nearly empty after reset
    apb(1, `REG_CTRL, 32'h101, 0);
    apb(1, `REG_ING_RATE, 1, 0);
    rx_frame(4, 4, 2'b10);
    chk(pause_req, 1);
    apb(1, `REG_ING_RATE, 0, 0);
    apb(1, `REG_EGR_RATE, 1, 0);
    t0 = n_tx;
    fork
      eg_send(2, 1);
    join_none
    repeat (300) @(posedge pclk);
    chk(n_tx - t0, 1);
    apb(1, `REG_EGR_RATE, 0, 0);
    wait_q();
    apb(1, `REG_ING_RATE, 8000, 0);
    apb(0, `REG_ING_RATE, 0, 8000);
    apb(1, `REG_ING_RATE, 8001, 0);
    apb(0, `REG_ING_RATE, 0, 8000);
    r = 1 + $urandom % 8000;
    apb(1, `REG_EGR_RATE, r, 0);
    apb(0, `REG_EGR_RATE, 0, r);
    apb(1, `REG_EGR_RATE, 0, 0);
    apb(1, `REG_ING_RATE, 0, 0);
    for (int s = 0; s < 3; s++) begin
      apb(1, `REG_CTRL, 32'h103 | s << 2 | (s & 1) << 4, 0);
      apb(0, `REG_CTRL, 0, 32'h103 | s << 2 | (s & 1) << 4);
      chk({an_enable, force_full, force_speed}, (s & 1) << 2 | s);
    end
    apb(1, `REG_CTRL, 32'h101, 0);
    apb(0, `REG_CTRL, 0, 33'h119);
    chk(force_speed, 2);
    fr_mode = 2;
    t0 = n_learn;
    rx_frame(6, 6, 2'b00);
    apb(1, `REG_CTRL, 32'h141, 0);
    rx_frame(6, 0, 2'b00);
    rx_frame(5, 5, 2'b10);
    chk(n_learn - t0, 1);
    apb(1, `REG_CTRL, 32'h181, 0);
    rx_frame(5, 0, 2'b11);
    apb(1, `REG_CTRL, 32'h101, 0);
    rx_frame(5, 5, 2'b11);
    lp.stall = 1'b1;
    eg_send(8, 1);
    wait_q();
    lp.stall = 1'b0;
    apb(1, `REG_CTRL, 32'h100, 0);
    rx_frame(5, 0, 2'b10);
    eg_send(3, 0);
    wait_q();
    fr_mode = 1;
    apb(1, `REG_CTRL, 32'h001, 0);
    rx_frame(1519, 1518, 2'b10);
    apb(1, `REG_CTRL, 32'h101, 0);
    rx_frame(2000, 2000, 2'b10);
    rx_frame(9217, 9216, 2'b10);
    apb(1, `REG_CTRL, 32'h121, 0);
    fr_mode = 0;
    rx_frame(14, 14, 2'b10);
    repeat (3) @(posedge pclk);
    chk(pause_req, 1);
    fr_mode = 1;
    wait_q();
    chk(pause_req, 0);
    apb(1, `REG_CTRL, 32'h101, 0);
    fr_mode = 0;
    loose = 1'b1;
    rx_frame(24, 0, 2'b10);
    chk(pause_req, 0);
    fr_mode = 1;
    repeat (40) @(posedge pclk);
    chk(last_fwd, 10'h300);
    // six refused frames: locked, storm, disabled, two oversize, overrun
    apb(0, `REG_DROPS, 0, 6);
    chk(exp_rd.size() + exp_fwd.size() + exp_tx.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
